// ===== pci_window_xlate.v
/*
  Inbound PCI target window translation. Holds two windows, claims
  PCI memory addresses that hit, and issues a system bus address by
  direct concatenation or via a page-map entry read from memory.
  Assumes a synchronous PCI request/claim port, a simple memory read
  port for map entries, and a plain register port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pci_window_defines.vh"

module pci_window_xlate (
  input wire ref_clk,
  input wire sys_rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // PCI side request
  input wire pci_req,
  input wire [31:0] pci_addr,
  output reg pci_claim,
  output reg pci_done,
  output reg pci_error,
  // Map-entry fetch port
  output reg map_rd,
  output reg [33:0] map_addr,
  input wire map_ack,
  input wire [63:0] map_data,
  // Translated system bus access
  output reg sys_valid,
  output reg [33:5] system_bus_address
);

  // ====================================================================
  // State encoding
  localparam ST_IDLE = 2'd0;
  localparam ST_FETCH = 2'd1;
  localparam ST_WAIT = 2'd2;

  // ====================================================================
  // Window registers
  reg [31:0] base0_r; // Window 0 base, enable, map bit
  reg [11:0] mask0_r; // Window 0 size mask
  reg [32:0] tbase0_r; // Window 0 translated base
  reg [31:0] base1_r; // Window 1 base, enable, map bit
  reg [11:0] mask1_r; // Window 1 size mask
  reg [32:0] tbase1_r; // Window 1 translated base
  reg err_r; // Sticky invalid-entry flag
  reg err_win_r; // Window that raised the error
  reg [1:0] state_r; // Translation sequencer
  reg [12:5] offset_r; // Page offset held during fetch
  reg win_r; // Window in use during fetch

  // ====================================================================
  // Window decode
  wire hit0;
  wire hit1;
  wire map0;
  wire map1;
  wire [32:5] dir0;
  wire [32:5] dir1;
  wire [32:3] ent0;
  wire [32:3] ent1;

  // Window 0 compare and address forming
  pci_window_match u_win0 (
    .pci_addr(pci_addr),
    .base_reg(base0_r),
    .mask_reg(mask0_r),
    .tbase_reg(tbase0_r),
    .hit(hit0),
    .map_mode(map0),
    .direct_addr(dir0),
    .entry_addr(ent0)
  );

  // Window 1 compare and address forming
  pci_window_match u_win1 (
    .pci_addr(pci_addr),
    .base_reg(base1_r),
    .mask_reg(mask1_r),
    .tbase_reg(tbase1_r),
    .hit(hit1),
    .map_mode(map1),
    .direct_addr(dir1),
    .entry_addr(ent1)
  );

  // Window 0 wins if software overlapped them anyway
  wire any_hit;
  wire sel1;
  assign any_hit = hit0 | hit1;
  assign sel1 = ~hit0;

  // ====================================================================
  // Register writes
  // Software programs windows; hardware sets the error flag
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      base0_r <= `BASE_RESET;
      mask0_r <= `MASK_RESET;
      tbase0_r <= `TBASE_RESET;
      base1_r <= `BASE_RESET;
      mask1_r <= `MASK_RESET;
      tbase1_r <= `TBASE_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_BASE0: base0_r <= {reg_wdata[31:20], 18'h00000, reg_wdata[1:0]};
        `REG_MASK0: mask0_r <= reg_wdata[31:20];
        `REG_TBASE0: tbase0_r <= {reg_wdata[27:0], 5'h00};
        `REG_BASE1: base1_r <= {reg_wdata[31:20], 18'h00000, reg_wdata[1:0]};
        `REG_MASK1: mask1_r <= reg_wdata[31:20];
        `REG_TBASE1: tbase1_r <= {reg_wdata[27:0], 5'h00};
        default: begin
          // Unmapped or status: nothing stored
        end
      endcase
    end
  end

  // ====================================================================
  // Register reads
  // Data appear the cycle after the read strobe; unmapped reads zero
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_BASE0: reg_rdata <= base0_r;
        `REG_MASK0: reg_rdata <= {mask0_r, 20'h00000};
        `REG_TBASE0: reg_rdata <= {4'h0, tbase0_r[32:5]};
        `REG_BASE1: reg_rdata <= base1_r;
        `REG_MASK1: reg_rdata <= {mask1_r, 20'h00000};
        `REG_TBASE1: reg_rdata <= {4'h0, tbase1_r[32:5]};
        `REG_STATUS: reg_rdata <= {29'h00000000, err_win_r, (state_r != ST_IDLE), err_r};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ====================================================================
  // Translation sequencer
  // Direct hits answer in one cycle; map hits fetch one quadword entry
  wire entry_valid;
  wire [33:5] page_addr;
  assign entry_valid = map_data[`ENTRY_VALID_BIT];
  // Entry bits 21:1 land on address bits 33:13; a legal entry keeps bit 21 clear
  assign page_addr = {map_data[`ENTRY_PAGE_MSB:`ENTRY_PAGE_LSB], offset_r};
  wire err_set;
  wire err_clr;
  assign err_set = (state_r == ST_WAIT) && map_ack && !entry_valid;
  assign err_clr = reg_wr && (reg_addr == `REG_STATUS) && reg_wdata[`STAT_ERR_BIT];

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      offset_r <= 8'h00;
      win_r <= 1'b0;
      pci_claim <= 1'b0;
      pci_done <= 1'b0;
      pci_error <= 1'b0;
      map_rd <= 1'b0;
      map_addr <= 34'h000000000;
      sys_valid <= 1'b0;
      system_bus_address <= 29'h00000000;
      err_r <= 1'b0;
      err_win_r <= 1'b0;
    end else begin
      pci_claim <= 1'b0;
      pci_done <= 1'b0;
      pci_error <= 1'b0;
      map_rd <= 1'b0;
      sys_valid <= 1'b0;
      // Set wins over a software clear in the same cycle
      if (err_set) begin
        err_r <= 1'b1;
        err_win_r <= win_r;
      end else if (err_clr) begin
        err_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          // Misses are never claimed
          if (pci_req && any_hit) begin
            pci_claim <= 1'b1;
            win_r <= sel1;
            offset_r <= pci_addr[12:5];
            if ((sel1 ? map1 : map0)) begin
              state_r <= ST_FETCH;
              map_addr <= {1'b0, (sel1 ? ent1 : ent0), 3'h0};
            end else begin
              sys_valid <= 1'b1;
              pci_done <= 1'b1;
              system_bus_address <= {1'b0, (sel1 ? dir1 : dir0)};
            end
          end
        end
        ST_FETCH: begin
          // Issue the single entry read
          map_rd <= 1'b1;
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          // Entry returned: translate or flag an invalid page
          if (map_ack) begin
            state_r <= ST_IDLE;
            pci_done <= 1'b1;
            if (entry_valid) begin
              sys_valid <= 1'b1;
              system_bus_address <= page_addr;
            end else begin
              pci_error <= 1'b1;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== pci_window_defines.vh
/*
  Constants for the PCI inbound target window translation block:
  register offsets, field positions, reset values and translation geometry.
  Assumes it is included by bare name by the design files.
*/
// Functional notes
// - Two independent windows, each three registers.
// - Mask covers PCI address bits 31:20.
// - Mask is right-aligned ones; n from 20..32.
// - Hit when all unmasked bits equal base.
// - Cleared enable bit blocks any hit.
// - Hit translates to 34-bit hexword address; mode bit.
// - Direct: translated base high bits plus PCI bits.
// - System address bit 33 zero in direct mode; map mode copies entry bit 21 into it.
// - Map mode: translated base locates page map.
// - Entry address: base above n-10, PCI n-1..13.
// - One quadword entry maps one 8KB page.
// - Entry bit0 valid, bits21:1 page from bit13.
`ifndef PCI_WINDOW_DEFINES_VH
`define PCI_WINDOW_DEFINES_VH

// ======================================================================
// Register map, word addresses on the register port
`define REG_ADDR_W 4
`define REG_BASE0 4'h0
`define REG_MASK0 4'h1
`define REG_TBASE0 4'h2
`define REG_BASE1 4'h4
`define REG_MASK1 4'h5
`define REG_TBASE1 4'h6
`define REG_STATUS 4'h8

// ======================================================================
// Base register fields
`define BASE_ENABLE_BIT 0
`define BASE_MAP_EN_BIT 1
`define BASE_ADDR_MSB 31
`define BASE_ADDR_LSB 20

// ======================================================================
// Status register fields
`define STAT_ERR_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_ERR_WIN_BIT 2

// ======================================================================
// Reset values
`define BASE_RESET 32'h00000000
`define MASK_RESET 12'h000
`define TBASE_RESET 33'h000000000

// ======================================================================
// Translation geometry
`define N_MIN 20
`define PAGE_LSB 13
`define OFFSET_LSB 5
`define MAP_SHIFT 10
`define ENTRY_VALID_BIT 0
`define ENTRY_PAGE_MSB 21
`define ENTRY_PAGE_LSB 1

`endif

// ===== pci_window_match.v
/*
  One inbound target window: decodes the size mask, compares the PCI
  address with the base, and forms the direct and map-entry addresses.
  Assumes the constants header and a synchronous caller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pci_window_defines.vh"

module pci_window_match (
  input wire [31:0] pci_addr,
  input wire [31:0] base_reg,
  input wire [11:0] mask_reg,
  input wire [32:0] tbase_reg,
  output wire hit,
  output wire map_mode,
  output wire [32:5] direct_addr,
  output wire [32:3] entry_addr
);

  // ====================================================================
  // Mask expansion
  // Full 32-bit keep mask: high bits compared where the size mask is clear, low 20 always ignored
  wire [31:0] cmp_mask;
  assign cmp_mask = {~mask_reg, 20'h00000};

  // ====================================================================
  // Window compare
  // Unmasked bits must match, and the window must be enabled
  assign hit = base_reg[`BASE_ENABLE_BIT] &&
    (((pci_addr ^ base_reg) & cmp_mask) == 32'h00000000);
  assign map_mode = base_reg[`BASE_MAP_EN_BIT];

  // ====================================================================
  // Direct translation
  // Bits n-1 to 20 come from the PCI address, bits at n and up from base, bits 19:5 from the OR of both
  wire [32:5] tb_dir;
  wire [32:5] pa_dir;
  assign tb_dir = tbase_reg[32:5] & ~{1'b0, mask_reg, 15'h0000};
  assign pa_dir = {1'b0, pci_addr[31:5]} & {1'b0, mask_reg, 15'h7fff};
  assign direct_addr = tb_dir | pa_dir;

  // ====================================================================
  // Map-entry address
  // Base above n-10 and PCI bits n-1 down to 13 as quadword index
  wire [32:3] tb_map;
  wire [32:3] pa_map;
  assign tb_map = tbase_reg[32:3] & ~{11'h000, mask_reg, 7'h7f};
  assign pa_map = {11'h000, pci_addr[31:13]} &
    {11'h000, mask_reg, 7'h7f};
  assign entry_addr = tb_map | pa_map;

endmodule
`default_nettype wire

// ===== pci_window_xlate_asserts.sv
/* Checker for the inbound PCI window translation block.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module pci_window_xlate_asserts (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic pci_req,
  input wire logic pci_claim,
  input wire logic pci_done,
  input wire logic pci_error,
  input wire logic map_rd,
  input wire logic [33:0] map_addr,
  input wire logic map_ack,
  input wire logic [63:0] map_data,
  input wire logic sys_valid,
  input wire logic [33:5] system_bus_address
);
  // ==========================================================
  // One clock, one synchronous reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  claim_needs_req_a: assert property (pci_claim |-> $past(pci_req)) else $error("claim without request");
  valid_with_done_a: assert property (sys_valid |-> pci_done && !pci_error) else $error("valid without done");
  error_with_done_a: assert property (pci_error |-> pci_done && !sys_valid) else $error("error without done");
  addr_top_zero_a: assert property (sys_valid |-> !system_bus_address[33]) else $error("address bit 33 set");
  fetch_addr_form_a: assert property (map_rd |-> map_addr[33] == 1'b0 && map_addr[2:0] == 3'h0)
    else $error("bad fetch address");
  fetch_after_claim_a: assert property (map_rd |-> $past(pci_claim)) else $error("fetch not after claim");
  done_after_ack_a: assert property (map_ack |=> pci_done) else $error("no done after entry");
  page_from_entry_a: assert property (sys_valid && $past(map_ack) |->
    system_bus_address[33:13] == $past(map_data[21:1])) else $error("page field wrong");
  invalid_entry_err_a: assert property (pci_error |-> $past(map_ack && !map_data[0]))
    else $error("error without invalid entry");
  rdata_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
endmodule
bind pci_window_xlate pci_window_xlate_asserts chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pci_req(pci_req), .pci_claim(pci_claim), .pci_done(pci_done), .pci_error(pci_error),
  .map_rd(map_rd), .map_addr(map_addr), .map_ack(map_ack), .map_data(map_data), .sys_valid(sys_valid),
  .system_bus_address(system_bus_address));
`default_nettype wire

// ===== map_memory_model.sv
/* System memory holding page map entries.
   Assumes one fetch at a time; page field follows the fetch address. */
`timescale 1ns/1ps
`default_nettype none
module map_memory_model (
  input wire logic ref_clk,
  input wire logic map_rd,
  input wire logic [33:0] map_addr,
  input wire logic entry_ok,
  input wire logic [1:0] wait_cycles,
  output logic map_ack,
  output logic [63:0] map_data
);
  logic [63:0] last_r; // Entry last returned
  initial begin
    map_ack = 1'b0;
    map_data = 64'h0;
    last_r = 64'h0;
  end
  // ==========================================================
  // Answer a fetch after a chosen delay, then drop the acknowledge and invert the data
  always @(posedge ref_clk) begin
    if (map_rd) begin
      repeat (wait_cycles) @(posedge ref_clk);
      last_r = {42'h0, 1'b0, map_addr[22:3], entry_ok};
      map_ack <= 1'b1;
      map_data <= last_r;
      @(posedge ref_clk);
      map_ack <= 1'b0;
      map_data <= ~last_r; // Bus driven with the inverted entry: no stale value
    end
  end
endmodule
`default_nettype wire

// ===== tb_pci_window_xlate.sv
/* Self-checking bench for the PCI window translation block.
   Assumes the map memory model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_pci_window_xlate;
  logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pci_req = 1'b0, entry_ok = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, pci_addr = 32'h0, reg_rdata;
  logic [1:0] wait_cycles = 2'h0;
  logic pci_claim, pci_done, pci_error, map_rd, map_ack, sys_valid;
  logic [33:0] map_addr;
  logic [63:0] map_data;
  logic [33:5] system_bus_address;
  int fail_count = 0, cmp_count = 0;
  always #25 ref_clk = ~ref_clk;
  pci_window_xlate dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pci_req(pci_req), .pci_addr(pci_addr),
    .pci_claim(pci_claim), .pci_done(pci_done), .pci_error(pci_error), .map_rd(map_rd), .map_addr(map_addr),
    .map_ack(map_ack), .map_data(map_data), .sys_valid(sys_valid), .system_bus_address(system_bus_address));
  map_memory_model mem (.ref_clk(ref_clk), .map_rd(map_rd), .map_addr(map_addr), .entry_ok(entry_ok),
    .wait_cycles(wait_cycles), .map_ack(map_ack), .map_data(map_data));
  // ==========================================================
  // Checking and verdict
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Register port cycles
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_check(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg", {32'h0, e}, {32'h0, reg_rdata});
  endtask
  // ==========================================================
  // One PCI request, watched until done or a bound runs out
  task automatic pci_xfer(input logic [31:0] a, input logic hit, input logic err, input logic [33:5] e);
    logic c, v, x, d;
    logic [33:5] got;
    c = 0; v = 0; x = 0; d = 0; got = '0;
    @(posedge ref_clk);
    pci_req <= 1'b1; pci_addr <= a;
    for (int k = 0; k < 12 && !d; k++) begin
      @(posedge ref_clk);
      if (k == 0) pci_req <= 1'b0;
      #1;
      c |= pci_claim; x |= pci_error; d = pci_done;
      if (sys_valid) begin v = 1; got = system_bus_address; end
    end
    chk("claim", hit, c);
    if (hit && !d) begin chk("done", 1, 0); report_and_stop; end
    chk("error", err, x);
    chk("valid", hit && !err, v);
    if (v) chk("sysaddr", e, got);
  endtask
  function automatic logic [32:0] ones(input int n);
    return (33'h1 << n) - 33'h1;
  endfunction
  function automatic logic [33:5] expect_addr(input logic [31:0] a, input int n, input logic [32:0] t, input logic sg);
    logic [33:0] x;
    logic [32:0] ea;
    x = {1'b0, (t & ~ones(n)) | ({1'b0, a} & ones(n))};
    ea = (t & ~ones(n - 10)) | ((({1'b0, a} & ones(n)) >> 13) << 3);
    return sg ? {1'b0, ea[22:3], a[12:5]} : x[33:5];
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    int n, w;
    logic sg;
    logic [31:0] b, a;
    logic [32:0] t;
    logic [3:0] regs [8];
    regs = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h3};
    void'($urandom(60768));
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (regs[j]) reg_check(regs[j], 32'h0);
    reg_write(4'h3, 32'hffffffff);
    reg_check(4'h3, 32'h0);
    for (int i = 0; i < 30; i++) begin
      w = i % 2; sg = (i % 3 == 0);
      n = (i < 13) ? 20 + i : 20 + $urandom % 13;
      b = $urandom & ~ones(n);
      t = {$urandom, $urandom} & ~ones(sg ? n - 10 : n) & ~33'h1f;
      entry_ok <= (i % 4 != 3); wait_cycles <= $urandom % 4;
      reg_write(w ? 4'h0 : 4'h4, 32'h0);
      reg_write(w * 4, {b[31:20], 18'h0, sg, 1'b1});
      reg_write(w * 4 + 1, {ones(n - 20), 20'h0});
      reg_write(w * 4 + 2, {4'h0, t[32:5]});
      reg_check(w * 4, {b[31:20], 18'h0, sg, 1'b1});
      a = b | ($urandom & ones(n));
      pci_xfer(a, 1, sg && entry_ok !== 1'b1, expect_addr(a, n, t, sg));
      if (sg && entry_ok !== 1'b1) begin
        reg_check(4'h8, {29'h0, w[0], 2'b01});
        reg_write(4'h8, 32'h1);
        reg_check(4'h8, {29'h0, w[0], 2'b00});
      end
      if (n < 32) pci_xfer(a ^ (32'h1 << n), 0, 0, '0);
      reg_write(w * 4, {b[31:20], 18'h0, sg, 1'b0});
      pci_xfer(a, 0, 0, '0);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
